// [dv/mbd_core_model.sv]
// Behavioural core that masters the decoder's memory bus
`default_nettype none
module mbd_core_model
    import mbd_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         ready_i,
    output logic              req_o,
    output logic              we_o,
    output logic              byte_o,
    output logic              fetch_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [15:0]       wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_o = 1'b0;
        we_o = 1'b0;
        byte_o = 1'b0;
        fetch_o = 1'b0;
        addr_o = 17'h0_0000;
        wdata_o = 16'h0000;
    end
    // Width and fetch kind come from the caller; only refusal scenarios break them
    task automatic acc(input logic f, w, b, input logic [ADDR_W-1:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk_i);
        while (ready_i !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        req_o = 1'b1;
        fetch_o = f;
        we_o = w;
        byte_o = b;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
    endtask
    task automatic idle();
        @(negedge clk_i);
        req_o = 1'b0;
        we_o = 1'b0;
        fetch_o = 1'b0;
        // Released bus shows junk, never the last address
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
endmodule
`default_nettype wire

// [dv/mbd_decode_asserts.sv]
// Port-level checks for the memory bus address decoder
`default_nettype none
module mbd_decode_asserts
    import mbd_pkg::*;
(
    input wire logic              CLK_I,
    input wire logic              RST_I,
    input wire logic              REQ_I,
    input wire logic              WE_I,
    input wire logic              BYTE_I,
    input wire logic              FETCH_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic              READY_O,
    input wire logic [N_TGT-1:0]  SEL_O,
    input wire logic [1:0]        TGT_BE_O,
    input wire logic [15:0]       RDATA_O,
    input wire logic              RVALID_O,
    input wire logic              ACC_ERR_O,
    input wire logic              PWR_CLR_O,
    input wire logic              VEC_HIT_O,
    input wire logic [3:0]        VEC_PRIO_O,
    input wire logic              PC_LOAD_O,
    input wire logic              DEV_OFF_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire acc = REQ_I && READY_O;
    one_sel_a: assert property (acc |-> $onehot(SEL_O))
        else $error("target select not one-hot");
    ram_sel_a: assert property (acc && ADDR_I >= RAM_START
        && ADDR_I < NVM_START_DEF |-> SEL_O[3]) else $error("RAM not selected");
    p16_byte_a: assert property (acc && !WE_I && BYTE_I && !FETCH_I && SEL_O[2]
        && !ADDR_I[0] |-> ##2 RVALID_O && RDATA_O[15:8] == 8'h00)
        else $error("16-bit byte read upper not zero");
    odd_word_a: assert property (acc && !BYTE_I && ADDR_I[0] |=> ACC_ERR_O)
        else $error("odd word access not refused");
    sfr_word_a: assert property (acc && !BYTE_I && ADDR_I <= SFR_END |=> ACC_ERR_O)
        else $error("word access to special registers not refused");
    p8_word_a: assert property (acc && WE_I && !BYTE_I && SEL_O[1] && !ADDR_I[0]
        |-> TGT_BE_O == 2'h1) else $error("word write to 8-bit target not low lane only");
    fetch_clr_a: assert property (acc && FETCH_I && ADDR_I <= P16_END
        |=> PWR_CLR_O ##1 !READY_O) else $error("peripheral fetch did not clear");
    vec_prio_a: assert property (acc && ADDR_I[16:5] == VEC_BASE[16:5]
        |-> VEC_HIT_O && VEC_PRIO_O == ADDR_I[4:1]) else $error("vector priority wrong");
    boot_load_a: assert property ($fell(RST_I) |-> ##3 (PC_LOAD_O || DEV_OFF_O))
        else $error("reset vector not loaded");
    cover property (PWR_CLR_O);
    cover property (ACC_ERR_O);
    cover property (PC_LOAD_O);
    cover property (DEV_OFF_O);
endmodule
bind mbd_decode mbd_decode_asserts mbd_decode_asserts_inst (.CLK_I(CLK_I), .RST_I(RST_I),
    .REQ_I(REQ_I), .WE_I(WE_I), .BYTE_I(BYTE_I), .FETCH_I(FETCH_I), .ADDR_I(ADDR_I),
    .READY_O(READY_O), .SEL_O(SEL_O), .TGT_BE_O(TGT_BE_O), .RDATA_O(RDATA_O),
    .RVALID_O(RVALID_O), .ACC_ERR_O(ACC_ERR_O), .PWR_CLR_O(PWR_CLR_O), .VEC_HIT_O(VEC_HIT_O),
    .VEC_PRIO_O(VEC_PRIO_O), .PC_LOAD_O(PC_LOAD_O), .DEV_OFF_O(DEV_OFF_O));
`default_nettype wire

// [dv/test_memory_bus_address_decode.sv]
// Self-checking bench for the memory bus address decoder
`default_nettype none
module test_memory_bus_address_decode
    import mbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, pin_rst = 1'b0;
    logic req, we, byt, ftch, ready, tgt_we, rvalid, err, pwr_clr, vhit, pcl, off;
    logic [16:0] addr, tgt_ad;
    logic [15:0] wd, rdata, pcv, tgt_wd;
    logic [15:0] p16_rd = 16'h5A3C, ram_rd = 16'h9E71, nvm_rd = 16'hC010;
    logic [7:0]  sfr_rd = 8'h6B, p8_rd = 8'hD2, ifg;
    logic [4:0]  sel;
    logic [3:0]  vprio;
    logic [1:0]  be;
    int n_errors = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    mbd_core_model mbd_core_model_inst (.clk_i(clk), .ready_i(ready), .req_o(req), .we_o(we),
        .byte_o(byt), .fetch_o(ftch), .addr_o(addr), .wdata_o(wd));
    mbd_decode mbd_decode_inst (.CLK_I(clk), .RST_I(rst), .PIN_RESET_I(pin_rst), .REQ_I(req),
        .WE_I(we), .BYTE_I(byt), .FETCH_I(ftch), .ADDR_I(addr), .WDATA_I(wd),
        .SFR_RDATA_I(sfr_rd), .P8_RDATA_I(p8_rd), .P16_RDATA_I(p16_rd), .RAM_RDATA_I(ram_rd),
        .NVM_RDATA_I(nvm_rd), .READY_O(ready), .SEL_O(sel), .TGT_ADDR_O(tgt_ad),
        .TGT_WE_O(tgt_we), .TGT_BE_O(be), .TGT_WDATA_O(tgt_wd), .RDATA_O(rdata),
        .RVALID_O(rvalid), .ACC_ERR_O(err), .PWR_CLR_O(pwr_clr), .VEC_HIT_O(vhit),
        .VEC_PRIO_O(vprio), .PC_LOAD_O(pcl), .PC_VALUE_O(pcv), .DEV_OFF_O(off), .IFG_ONE_O(ifg));
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic op(input logic f, w, b, input logic [16:0] a, input logic [15:0] d);
        mbd_core_model_inst.acc(f, w, b, a, d);
        #1;
        chk("op_ready", 1'b1, ready);
    endtask
    task automatic nxt();
        @(posedge clk);
        #1;
    endtask
    task automatic wait_boot();
        int n;
        n = 0;
        while (pcl !== 1'b1 && n < 20) begin
            nxt();
            n++;
        end
        chk("pc_load", 1'b1, pcl);
        chk("pc_value", nvm_rd, pcv);
    endtask
    task automatic t_map();
        logic [16:0] ta [5] = '{17'h0_0004, 17'h0_0020, 17'h0_0102, 17'h0_0204, 17'h0_C000};
        logic [7:0]  te [5] = '{sfr_rd, p8_rd, p16_rd[7:0], ram_rd[7:0], nvm_rd[7:0]};
        for (int i = 0; i < 5; i++) begin
            op(1'b0, 1'b0, 1'b1, ta[i], 16'h0000);
            chk("sel", 17'(1 << i), sel);
            mbd_core_model_inst.idle();
            nxt();
            chk("rvalid", 1'b1, rvalid);
            chk("rdata", {8'h00, te[i]}, rdata);
        end
        op(1'b0, 1'b0, 1'b1, 17'h0_0205, 16'h0000);
        mbd_core_model_inst.idle();
        nxt();
        chk("odd_byte", {8'h00, ram_rd[15:8]}, rdata);
    endtask
    task automatic t_width();
        op(1'b0, 1'b1, 1'b0, 17'h0_0020, 16'hBEEF);
        chk("be_p8", 2'h1, be);
        chk("wd_word", 16'hBEEF, tgt_wd);
        op(1'b0, 1'b1, 1'b0, 17'h0_0206, 16'h1234);
        chk("be_word", 2'h3, be);
        chk("we_word", 1'b1, tgt_we);
        chk("ta_word", 17'h0_0206, tgt_ad);
        op(1'b0, 1'b1, 1'b1, 17'h0_0207, 16'h00AB);
        chk("be_odd", 2'h2, be);
        chk("wd_byte", 16'hABAB, tgt_wd);
        chk("ta_byte", 17'h0_0207, tgt_ad);
        op(1'b0, 1'b0, 1'b0, 17'h0_0206, 16'h0000);
        mbd_core_model_inst.idle();
        nxt();
        chk("ram_word", ram_rd, rdata);
        op(1'b0, 1'b0, 1'b0, 17'h0_0020, 16'h0000);
        mbd_core_model_inst.idle();
        nxt();
        chk("p8_word", {8'h00, p8_rd}, rdata);
        op(1'b0, 1'b0, 1'b0, 17'h0_FFE4, 16'h0000);
        chk("vec_hit", 1'b1, vhit);
        chk("vec_prio", 4'h2, vprio);
        mbd_core_model_inst.idle();
    endtask
    task automatic t_refuse();
        logic [2:0]  tk [5] = '{3'h2, 3'h4, 3'h2, 3'h3, 3'h2};
        logic [16:0] ta [5] = '{17'h0_0205, 17'h0_0201, 17'h0_0002, 17'h0_0103, 17'h1_0000};
        for (int i = 0; i < 5; i++) begin
            op(tk[i][2], tk[i][1], tk[i][0], ta[i], 16'hA55A);
            chk("err_we", 1'b0, tgt_we);
            chk("err_be", 2'h0, be);
            mbd_core_model_inst.idle();
            chk("err", 1'b1, err);
        end
    endtask
    task automatic t_flags();
        int n;
        op(1'b0, 1'b1, 1'b1, 17'h0_0002, 16'h0000);
        mbd_core_model_inst.idle();
        nxt();
        chk("ifg_clr", 8'h00, ifg);
        @(negedge clk);
        pin_rst = 1'b1;
        repeat (4) @(negedge clk);
        pin_rst = 1'b0;
        n = 0;
        while (ifg[3] !== 1'b1 && n < 10) begin
            nxt();
            n++;
        end
        chk("ifg_pin", 8'h08, ifg);
        op(1'b0, 1'b0, 1'b1, 17'h0_0002, 16'h0000);
        mbd_core_model_inst.idle();
        nxt();
        chk("ifg_read", 17'h0_0008, rdata);
    endtask
    task automatic t_puc();
        op(1'b1, 1'b0, 1'b0, 17'h0_0100, 16'h0000);
        mbd_core_model_inst.idle();
        chk("pwr_clr", 1'b1, pwr_clr);
        nxt();
        chk("ready", 1'b0, ready);
        wait_boot();
        chk("ifg_kept", 8'h08, ifg);
    endtask
    task automatic t_off();
        @(negedge clk);
        nvm_rd = 16'hFFFF;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (6) nxt();
        chk("ifg_por", 8'h04, ifg);
        chk("dev_off", 1'b1, off);
        chk("off_ready", 1'b0, ready);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        wait_boot();
        chk("ifg_reset", 8'h04, ifg);
        t_map();
        t_width();
        t_refuse();
        t_flags();
        t_puc();
        t_off();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire

// [verilog/mbd_decode.sv]
// Memory bus address decoder with byte/word steering and boot vector fetch
// Behaviour
// RL1: Decode one unified 128 KB space for code, data, special registers, peripherals.
// RL2: Fetches need even addresses; data accesses are byte or word.
// RL3: Nonvolatile region ends at 0FFFF; its start depends on fitted size.
// RL4: Vector table is top 16 words; 0FFFE highest priority, falling downward.
// RL5: RAM starts at 0200h, end depends on size, holds code or data.
// RL6: 0100-01FFh are 16-bit peripherals; bytes only even, upper byte zero.
// RL7: 010h-0FFh are 8-bit peripherals; word read upper byte undefined.
// RL8: Word write to 8-bit peripheral stores only the lower byte.
// RL9: Special registers in lowest 16 bytes, byte access only.
// RL10: Words at even addresses, low byte even, high byte next odd.
// RL11: A fetch from 0000-01FF triggers a device reset.
// RL12: First flag register holds power-on and pin reset cause flags.
// RL13: Fetch-caused reset is a power-up clear, not a power-on reset.
// RL14: After reset load PC from top vector; 0FFFFh disables device.
// RL15: Every access asserts exactly one target select from its address.
`default_nettype none
module mbd_decode
    import mbd_pkg::*;
#(
    parameter logic [16:0] NVM_START = NVM_START_DEF,
    parameter logic [16:0] NVM_END   = NVM_END_SMALL
) (
    input  wire logic              CLK_I,
    input  wire logic              RST_I,
    input  wire logic              PIN_RESET_I,
    input  wire logic              REQ_I,
    input  wire logic              WE_I,
    input  wire logic              BYTE_I,
    input  wire logic              FETCH_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [15:0]       WDATA_I,
    input  wire logic [7:0]        SFR_RDATA_I,
    input  wire logic [7:0]        P8_RDATA_I,
    input  wire logic [15:0]       P16_RDATA_I,
    input  wire logic [15:0]       RAM_RDATA_I,
    input  wire logic [15:0]       NVM_RDATA_I,
    output logic                   READY_O,
    output logic [N_TGT-1:0]       SEL_O,
    output logic [ADDR_W-1:0]      TGT_ADDR_O,
    output logic                   TGT_WE_O,
    output logic [1:0]             TGT_BE_O,
    output logic [15:0]            TGT_WDATA_O,
    output logic [15:0]            RDATA_O,
    output logic                   RVALID_O,
    output logic                   ACC_ERR_O,
    output logic                   PWR_CLR_O,
    output logic                   VEC_HIT_O,
    output logic [3:0]             VEC_PRIO_O,
    output logic                   PC_LOAD_O,
    output logic [15:0]            PC_VALUE_O,
    output logic                   DEV_OFF_O,
    output logic [7:0]             IFG_ONE_O
);
    mbd_flag_if fif ();

    mbd_flags u_flags (
        .CLK_I (CLK_I),
        .RST_I (RST_I),
        .fif   (fif)
    );

    function automatic logic [N_TGT-1:0] decode_sel(input logic [ADDR_W-1:0] a);
        logic [N_TGT-1:0] s;
        s = '0;
        if (a <= SFR_END) begin
            s[SEL_SFR] = 1'b1; // RL9
        end else if (a <= P8_END) begin
            s[SEL_P8] = 1'b1; // RL7
        end else if (a <= P16_END) begin
            s[SEL_P16] = 1'b1; // RL6
        end else if (a < NVM_START) begin
            s[SEL_RAM] = 1'b1; // RL5
        end else begin
            s[SEL_NVM] = 1'b1; // RL3
        end
        return s; // RL15
    endfunction

    // Pin reset synchroniser
    logic [1:0] pin_sync_q;
    logic [1:0] pin_sync_d;
    logic       pin_prev_q;
    logic       pin_prev_d;

    always_comb begin
        pin_sync_d = {pin_sync_q[0], PIN_RESET_I};
        pin_prev_d = pin_sync_q[1];
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pin_sync_q <= 2'b00;
            pin_prev_q <= 1'b0;
        end else begin
            pin_sync_q <= pin_sync_d;
            pin_prev_q <= pin_prev_d;
        end
    end

    // Boot sequencer
    mbd_boot_e  st_q;
    mbd_boot_e  st_d;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic        pcl_q;
    logic        pcl_d;

    // Access decode
    logic [N_TGT-1:0] sel;
    logic [ADDR_W-1:0] addr;
    logic              act;
    logic              err;
    logic              wr;
    logic [1:0]        be;
    logic [15:0]       wdat;
    logic              is_byte;
    logic              ifg_hit;

    always_comb begin
        addr    = (st_q == BOOT_REQ) ? RESET_VEC_ADDR : ADDR_I;
        act     = (st_q == BOOT_REQ) || (REQ_I && st_q == RUN);
        is_byte = BYTE_I && st_q == RUN;
        sel     = act ? decode_sel(addr) : '0; // RL1
        err     = 1'b0;
        if (act && st_q == RUN) begin
            if (!BYTE_I && addr[0]) begin
                err = 1'b1; // RL10
            end
            if (FETCH_I && (addr[0] || WE_I)) begin
                err = 1'b1; // RL2
            end
            if (sel[SEL_SFR] && !BYTE_I) begin
                err = 1'b1; // RL9
            end
            if (sel[SEL_P16] && BYTE_I && addr[0]) begin
                err = 1'b1; // RL6
            end
            if (sel[SEL_NVM] && addr > NVM_END) begin
                err = 1'b1; // RL3
            end
        end
        wr = act && (st_q == RUN) && WE_I && !err;
        if (!wr) begin
            be = 2'b00;
        end else if (is_byte) begin
            be = addr[0] ? 2'b10 : 2'b01; // RL10
        end else if (sel[SEL_P8]) begin
            be = 2'b01; // RL8
        end else begin
            be = 2'b11;
        end
        // Byte data rides in the low lane from the core; copy to both lanes
        wdat    = is_byte ? {WDATA_I[7:0], WDATA_I[7:0]} : WDATA_I; // RL10
        ifg_hit = wr && sel[SEL_SFR] && addr[7:0] == IFG_ONE_OFS;
    end

    assign READY_O     = (st_q == RUN);
    assign SEL_O       = sel;
    assign TGT_ADDR_O  = {addr[ADDR_W-1:1], addr[0] & is_byte};
    assign TGT_WE_O    = wr;
    assign TGT_BE_O    = be;
    assign TGT_WDATA_O = wdat;
    assign VEC_HIT_O   = act && (addr >= VEC_BASE) && (addr <= NVM_END_SMALL); // RL4
    assign VEC_PRIO_O  = addr[4:1]; // RL4
    assign fif.wr      = ifg_hit; // RL12
    assign fif.wdata   = wdat[7:0];
    assign fif.pin_evt = pin_sync_q[1] && !pin_prev_q; // RL12

    // Read steering pipeline: targets answer one cycle after select
    logic [N_TGT-1:0] rsel_q;
    logic [N_TGT-1:0] rsel_d;
    logic             rbyte_q;
    logic             rbyte_d;
    logic             rodd_q;
    logic             rodd_d;
    logic             rifg_q;
    logic             rifg_d;
    logic             rrun_q;
    logic             rrun_d;
    logic [15:0]      rdat_q;
    logic [15:0]      rdat_d;
    logic             rval_q;
    logic             rval_d;
    logic             err_q;
    logic             err_d;
    logic             pwr_clr_q;
    logic             pwr_clr_d;
    logic [15:0]      raw;
    logic [7:0]       sfr_b;

    always_comb begin
        rsel_d  = (act && !WE_I) || st_q == BOOT_REQ ? sel : '0;
        rbyte_d = is_byte;
        rodd_d  = addr[0];
        rifg_d  = sel[SEL_SFR] && addr[7:0] == IFG_ONE_OFS;
        rrun_d  = (st_q == RUN);
        err_d   = err;
        pwr_clr_d = act && (st_q == RUN) && FETCH_I && (addr <= P16_END); // RL11 RL13
        sfr_b   = rifg_q ? fif.rdata : SFR_RDATA_I;
        raw     = 16'h0000;
        case (1'b1)
            rsel_q[SEL_SFR]: raw = {8'h00, sfr_b};
            rsel_q[SEL_P8]:  raw = {UNDEF_HI_BYTE, P8_RDATA_I}; // RL7
            rsel_q[SEL_P16]: raw = rbyte_q ? {8'h00, P16_RDATA_I[7:0]} : P16_RDATA_I; // RL6
            rsel_q[SEL_RAM]: raw = RAM_RDATA_I;
            rsel_q[SEL_NVM]: raw = NVM_RDATA_I;
            default:         raw = 16'h0000;
        endcase
        rdat_d = raw;
        if (rbyte_q && !rsel_q[SEL_SFR] && !rsel_q[SEL_P8] && !rsel_q[SEL_P16]) begin
            rdat_d = {8'h00, rodd_q ? raw[15:8] : raw[7:0]}; // RL10
        end
        rval_d = (|rsel_q) && rrun_q;
        pcl_d  = 1'b0;
        pc_d   = pc_q;
        st_d   = st_q;
        case (st_q)
            BOOT_REQ:  st_d = BOOT_WAIT;
            BOOT_WAIT: st_d = BOOT_CAP;
            BOOT_CAP: begin
                pc_d = NVM_RDATA_I; // RL14
                // All-ones vector means erased part; park for minimum power
                if (NVM_RDATA_I == VEC_DISABLE) begin
                    st_d = HALTED; // RL14
                end else begin
                    st_d  = RUN;
                    pcl_d = 1'b1; // RL14
                end
            end
            RUN:     st_d = RUN;
            HALTED:  st_d = HALTED;
            default: st_d = BOOT_REQ;
        endcase
        // Power-up clear reloads the vector but keeps the cause flags
        if (pwr_clr_q) begin
            st_d = BOOT_REQ; // RL13
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_q    <= BOOT_REQ;
            pc_q    <= 16'h0000;
            pcl_q   <= 1'b0;
            rsel_q  <= '0;
            rbyte_q <= 1'b0;
            rodd_q  <= 1'b0;
            rifg_q  <= 1'b0;
            rrun_q  <= 1'b0;
            rdat_q  <= 16'h0000;
            rval_q  <= 1'b0;
            err_q   <= 1'b0;
            pwr_clr_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            pc_q    <= pc_d;
            pcl_q   <= pcl_d;
            rsel_q  <= rsel_d;
            rbyte_q <= rbyte_d;
            rodd_q  <= rodd_d;
            rifg_q  <= rifg_d;
            rrun_q  <= rrun_d;
            rdat_q  <= rdat_d;
            rval_q  <= rval_d;
            err_q   <= err_d;
            pwr_clr_q <= pwr_clr_d;
        end
    end

    assign RDATA_O    = rdat_q;
    assign RVALID_O   = rval_q;
    assign ACC_ERR_O  = err_q;
    assign PWR_CLR_O  = pwr_clr_q;
    assign PC_LOAD_O  = pcl_q;
    assign PC_VALUE_O = pc_q;
    assign DEV_OFF_O  = (st_q == HALTED);
    assign IFG_ONE_O  = fif.rdata;
endmodule
`default_nettype wire

// [verilog/mbd_flag_if.sv]
// Carrier between decoder and the reset-cause flag register
`default_nettype none
interface mbd_flag_if;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       pin_evt;
    modport dec (output wr, output wdata, output pin_evt, input rdata);
    modport flg (input wr, input wdata, input pin_evt, output rdata);
endinterface
`default_nettype wire

// [verilog/mbd_flags.sv]
// First interrupt flag register holding the reset-cause flags
`default_nettype none
module mbd_flags
    import mbd_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic RST_I,
    mbd_flag_if.flg   fif
);
    logic [7:0] ifg_q;
    logic [7:0] ifg_d;

    always_comb begin
        ifg_d = ifg_q;
        if (fif.wr) begin
            ifg_d = fif.wdata;
        end
        // Hardware set wins over a software clear in the same cycle
        if (fif.pin_evt) begin
            ifg_d[PIN_FLAG_BIT] = 1'b1; // RL12
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ifg_q <= IFG_ONE_RESET; // RL12
        end else begin
            ifg_q <= ifg_d;
        end
    end

    assign fif.rdata = ifg_q;
endmodule
`default_nettype wire

// [verilog/mbd_pkg.sv]
// Constants and types shared by the memory bus address decoder
`default_nettype none
package mbd_pkg;
    localparam int unsigned ADDR_W         = 17;
    localparam logic [16:0] SFR_END        = 17'h0_000F;
    localparam logic [16:0] P8_END         = 17'h0_00FF;
    localparam logic [16:0] P16_END        = 17'h0_01FF;
    localparam logic [16:0] RAM_START      = 17'h0_0200;
    localparam logic [16:0] NVM_END_SMALL  = 17'h0_FFFF;
    localparam logic [16:0] NVM_START_DEF  = 17'h0_C000;
    localparam logic [16:0] VEC_BASE       = 17'h0_FFE0;
    localparam logic [16:0] RESET_VEC_ADDR = 17'h0_FFFE;
    localparam logic [15:0] VEC_DISABLE    = 16'hFFFF;
    localparam logic [7:0]  IFG_ONE_OFS    = 8'h02;
    localparam int unsigned POR_FLAG_BIT   = 2;
    localparam int unsigned PIN_FLAG_BIT   = 3;
    localparam logic [7:0]  IFG_ONE_RESET  = 8'h04;
    localparam logic [7:0]  UNDEF_HI_BYTE  = 8'h00;
    localparam int unsigned SEL_SFR        = 0;
    localparam int unsigned SEL_P8         = 1;
    localparam int unsigned SEL_P16        = 2;
    localparam int unsigned SEL_RAM        = 3;
    localparam int unsigned SEL_NVM        = 4;
    localparam int unsigned N_TGT          = 5;
    typedef enum logic [2:0] {BOOT_REQ, BOOT_WAIT, BOOT_CAP, RUN, HALTED} mbd_boot_e;
endpackage
`default_nettype wire
